// [hw/sensor_defs.svh]
// constants of the sensor state and heater controller
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH

// ********************************
// register map and link addresses
// ********************************
`define CTRL_OFFSET 8'h0C
`define STATUS_OFFSET 8'h09
`define CTRL_RESET 8'h00
`define ADDR_NORMAL 7'h28
`define ADDR_BOOT_FAULT 7'h4C
`define BYTE_BITS 4'h8

// ********************************
// field codes
// ********************************
`define OP_SLEEP 3'h0
`define OP_MEASURE 3'h1
`define OP_PROHIBITED 3'h2
`define OP_RESET 3'h4
`define STBY_100 3'h2
`define STBY_400 3'h3
`define STBY_1000 3'h4
`define STBY_ONE_SHOT 3'h7
`define CODE_SLEEP 3'h0
`define CODE_MEASURE 3'h1
`define CODE_STANDBY 3'h5

// ********************************
// timing
// ********************************
`define CLOCK_KHZ 200000
`define STBY_100_MS 100
`define STBY_400_MS 400
`define STBY_1000_MS 1000
`define WAKE_CYCLES 5'h10
`define TIMER_W 28

`endif

// [hw/sensor_pkg.sv]
// types shared by the sensor state and heater controller
package sensor_pkg;

  // operating states of the device
  typedef enum logic [2:0] {
    st_sleep = 3'b000,
    st_measure = 3'b001,
    st_boot = 3'b100,
    st_standby = 3'b101,
    st_wake = 3'b110
  } op_state_type;

  // serial slave progress
  typedef enum logic [2:0] {
    link_idle = 3'b000,
    link_addr = 3'b001,
    link_addr_ack = 3'b010,
    link_write = 3'b011,
    link_write_ack = 3'b100,
    link_read = 3'b101,
    link_read_ack = 3'b110
  } link_state_type;

  typedef struct packed {
    logic reserved;
    logic [2:0] standby_interval;
    logic heater_on;
    logic [2:0] op_request;
  } control_type;

  typedef struct packed {
    logic reserved;
    logic heater_fault;
    logic boot_load_fault_flag;
    logic setting_fault;
    logic data_ready;
    logic [2:0] state_code;
  } status_type;

endpackage : sensor_pkg

// [hw/pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clock_en,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;

  // first stage feeds only the second; filter looks at 2nd and 3rd
  always_comb begin
    next_stage = {stage[1:0], i_pin};
    next_level = (stage[2] == stage[1]) ? stage[1] : o_level;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage <= {3{INIT}};
      o_level <= INIT;
    end else if (i_clock_en) begin
      stage <= next_stage;
      o_level <= next_level;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [hw/sensor_state_heater_control.sv]
// operating state, heater and serial register access of the sensor
`timescale 1ns/10ps
`default_nettype none
`include "sensor_defs.svh"
module sensor_state_heater_control
  import sensor_pkg::*;
#(
  parameter int unsigned STBY_100_CYCLES = `STBY_100_MS * `CLOCK_KHZ,
  parameter int unsigned STBY_400_CYCLES = `STBY_400_MS * `CLOCK_KHZ,
  parameter int unsigned STBY_1000_CYCLES = `STBY_1000_MS * `CLOCK_KHZ
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clock_en,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_heater_overcurrent,
  input wire logic i_conversion_done,
  input wire logic i_boot_done,
  input wire logic i_boot_fail,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_heater_on,
  output logic o_conversion_start,
  output logic o_boot_start,
  output logic o_data_ready,
  output logic [2:0] o_state
);
  // ********************************
  // pin synchronisers
  // ********************************
  logic scl;
  logic sda;
  logic overcurrent;

  pin_sync #(.INIT(1'b1)) scl_sync (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_clock_en(i_clock_en), .i_pin(i_scl),
    .o_level(scl));
  pin_sync #(.INIT(1'b1)) sda_sync (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_clock_en(i_clock_en), .i_pin(i_sda),
    .o_level(sda));
  pin_sync #(.INIT(1'b0)) oc_sync (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_clock_en(i_clock_en),
    .i_pin(i_heater_overcurrent), .o_level(overcurrent));

  // ********************************
  // state declarations
  // ********************************
  op_state_type op_state, next_op_state;
  control_type ctrl, next_ctrl;
  status_type status;
  logic heater_fault, next_heater_fault;
  logic boot_fault, next_boot_fault;
  logic setting_fault, next_setting_fault;
  logic data_ready, next_data_ready;
  logic boot_started, next_boot_started;
  logic conv_pulse, boot_pulse;
  logic [`TIMER_W-1:0] timer, next_timer;
  logic [4:0] wake_cnt, next_wake_cnt;

  link_state_type link, next_link;
  logic scl_prev, sda_prev;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic [7:0] pointer, next_pointer;
  logic first, next_first;
  logic rw, next_rw;
  logic mack, next_mack;
  logic sda_release, next_sda_release;
  logic wr_ctrl;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [6:0] own_addr;
  logic [7:0] read_data;

  // status code seen by the host; transient states fold into neighbours
  function automatic logic [2:0] state_code(input op_state_type s);
    case (s)
      st_measure: state_code = `CODE_MEASURE;
      st_standby: state_code = `CODE_STANDBY;
      st_wake: state_code = `CODE_STANDBY;
      default: state_code = `CODE_SLEEP;
    endcase
  endfunction : state_code

  // ********************************
  // serial slave
  // ********************************
  assign scl_rise = scl & ~scl_prev;
  assign scl_fall = ~scl & scl_prev;
  assign start_cond = scl & scl_prev & sda_prev & ~sda;
  assign stop_cond = scl & scl_prev & ~sda_prev & sda;
  assign own_addr = boot_fault ? `ADDR_BOOT_FAULT : `ADDR_NORMAL;
  assign status = '{reserved: 1'b0, heater_fault: heater_fault,
    boot_load_fault_flag: boot_fault, setting_fault: setting_fault,
    data_ready: data_ready, state_code: state_code(op_state)};
  // unmapped pointers read as zero
  assign read_data = (pointer == `CTRL_OFFSET) ? ctrl :
    (pointer == `STATUS_OFFSET) ? status : 8'h00;

  // bits sampled on scl rise, sda driven on scl fall
  always_comb begin
    next_link = link;
    next_cnt = cnt;
    next_shift = shift;
    next_tx = tx;
    next_pointer = pointer;
    next_first = first;
    next_rw = rw;
    next_mack = mack;
    next_sda_release = sda_release;
    wr_ctrl = 1'b0;
    if (start_cond) begin
      next_link = link_addr;
      next_cnt = 4'h0;
      next_sda_release = 1'b1;
    end else if (stop_cond) begin
      next_link = link_idle;
      next_sda_release = 1'b1;
    end else if (scl_rise) begin
      next_shift = {shift[6:0], sda};
      next_cnt = cnt + 4'h1;
      next_mack = ~sda;
    end else if (scl_fall) begin
      case (link)
        link_addr: begin
          if (cnt == `BYTE_BITS) begin
            next_cnt = 4'h0;
            if (shift[7:1] == own_addr && op_state != st_wake) begin
              next_sda_release = 1'b0;
              next_rw = shift[0];
              next_link = link_addr_ack;
            end else begin
              next_link = link_idle;
            end
          end
        end
        link_addr_ack: begin
          next_cnt = 4'h0;
          if (rw) begin
            next_tx = read_data;
            next_sda_release = read_data[7];
            next_link = link_read;
          end else begin
            next_sda_release = 1'b1;
            next_first = 1'b1;
            next_link = link_write;
          end
        end
        link_write: begin
          if (cnt == `BYTE_BITS) begin
            next_cnt = 4'h0;
            next_sda_release = 1'b0;
            next_link = link_write_ack;
            next_first = 1'b0;
            if (first) begin
              next_pointer = shift;
            end else if (pointer == `CTRL_OFFSET) begin
              wr_ctrl = 1'b1;
            end
          end
        end
        link_write_ack: begin
          next_cnt = 4'h0;
          next_sda_release = 1'b1;
          next_link = link_write;
        end
        link_read: begin
          if (cnt == `BYTE_BITS) begin
            next_cnt = 4'h0;
            next_sda_release = 1'b1;
            next_link = link_read_ack;
          end else begin
            next_tx = {tx[6:0], 1'b0};
            next_sda_release = tx[6];
          end
        end
        link_read_ack: begin
          next_cnt = 4'h0;
          if (mack) begin
            next_tx = read_data;
            next_sda_release = read_data[7];
            next_link = link_read;
          end else begin
            next_link = link_idle;
          end
        end
        default: next_link = link_idle;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link <= link_idle;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      pointer <= 8'h00;
      first <= 1'b0;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_release <= 1'b1;
    end else if (i_clock_en) begin
      link <= next_link;
      scl_prev <= scl;
      sda_prev <= sda;
      cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      pointer <= next_pointer;
      first <= next_first;
      rw <= next_rw;
      mack <= next_mack;
      sda_release <= next_sda_release;
    end
  end

  // ********************************
  // operating state and heater
  // ********************************
  always_comb begin
    next_op_state = op_state;
    next_ctrl = ctrl;
    next_heater_fault = heater_fault;
    next_boot_fault = boot_fault;
    next_setting_fault = setting_fault;
    next_data_ready = data_ready;
    next_boot_started = boot_started;
    next_timer = timer;
    next_wake_cnt = wake_cnt;
    conv_pulse = 1'b0;
    boot_pulse = 1'b0;
    case (op_state)
      st_boot: begin
        if (!boot_started) begin
          next_boot_started = 1'b1;
          boot_pulse = 1'b1;
        end else if (i_boot_done) begin
          next_op_state = st_sleep;
          next_boot_fault = i_boot_fail;
        end
      end
      st_standby: begin
        if (timer == '0) begin
          next_op_state = st_wake;
          next_wake_cnt = `WAKE_CYCLES;
        end else begin
          next_timer = timer - `TIMER_W'(1);
        end
      end
      st_wake: begin
        if (wake_cnt == 5'h00) begin
          next_op_state = st_measure;
          conv_pulse = 1'b1;
        end else begin
          next_wake_cnt = wake_cnt - 5'h01;
        end
      end
      st_measure: begin
        if (i_conversion_done) begin
          next_data_ready = 1'b1;
          next_op_state = st_standby;
          case (ctrl.standby_interval)
            `STBY_100: next_timer = `TIMER_W'(STBY_100_CYCLES - 1);
            `STBY_400: next_timer = `TIMER_W'(STBY_400_CYCLES - 1);
            `STBY_1000: next_timer = `TIMER_W'(STBY_1000_CYCLES - 1);
            // one-shot and test codes end in sleep
            default: next_op_state = st_sleep;
          endcase
          if (ctrl.op_request != `OP_MEASURE) begin
            next_op_state = st_sleep;
          end
        end
      end
      default: next_op_state = op_state;
    endcase
    // request decode; writes during boot only honour reset
    if (wr_ctrl && (op_state != st_boot || shift[2:0] == `OP_RESET)) begin
      // layout with bit 7 forced to zero
      next_ctrl = control_type'({1'b0, shift[6:0]});
      case (shift[2:0])
        `OP_RESET: begin
          // reset control and all flags and rerun boot load
          next_ctrl = control_type'(`CTRL_RESET);
          next_op_state = st_boot;
          next_boot_started = 1'b0;
          next_boot_fault = 1'b0;
          next_setting_fault = 1'b0;
          next_data_ready = 1'b0;
        end
        `OP_MEASURE: begin
          next_setting_fault = 1'b0;
          if (op_state != st_measure) begin
            next_op_state = st_measure;
            conv_pulse = 1'b1;
            next_data_ready = 1'b0;
          end
        end
        `OP_SLEEP, `OP_PROHIBITED: begin
          // prohibited code only flags and sleeps
          next_setting_fault = (shift[2:0] == `OP_PROHIBITED);
          if (op_state == st_standby || op_state == st_wake) begin
            next_op_state = st_sleep;
          end
        end
        default: next_ctrl.op_request = ctrl.op_request;
      endcase
    end
    // clear on heater off, set wins over clear
    if (!next_ctrl.heater_on) begin
      next_heater_fault = 1'b0;
    end
    if (overcurrent && next_ctrl.heater_on) begin
      next_heater_fault = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // power-up runs the boot load first
      op_state <= st_boot;
      ctrl <= control_type'(`CTRL_RESET);
      heater_fault <= 1'b0;
      boot_fault <= 1'b0;
      setting_fault <= 1'b0;
      data_ready <= 1'b0;
      boot_started <= 1'b0;
      timer <= '0;
      wake_cnt <= 5'h00;
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_heater_on <= 1'b0;
      o_conversion_start <= 1'b0;
      o_boot_start <= 1'b0;
      o_data_ready <= 1'b0;
      o_state <= `CODE_SLEEP;
    end else if (i_clock_en) begin
      op_state <= next_op_state;
      ctrl <= next_ctrl;
      heater_fault <= next_heater_fault;
      boot_fault <= next_boot_fault;
      setting_fault <= next_setting_fault;
      data_ready <= next_data_ready;
      boot_started <= next_boot_started;
      timer <= next_timer;
      wake_cnt <= next_wake_cnt;
      o_sda_out <= 1'b0;
      o_sda_oe_n <= next_sda_release;
      // heater drive, cut by a fault
      o_heater_on <= next_ctrl.heater_on & ~next_heater_fault;
      o_conversion_start <= conv_pulse;
      o_boot_start <= boot_pulse;
      o_data_ready <= next_data_ready;
      o_state <= state_code(next_op_state);
    end
  end

  // ********************************
  // assertions
  // ********************************
  sequence reset_write_s;
    i_clock_en && wr_ctrl && shift[2:0] == `OP_RESET;
  endsequence
  sequence boot_entered_s;
    op_state == st_boot && ctrl == control_type'(`CTRL_RESET);
  endsequence

  heater_drive_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_heater_on == (ctrl.heater_on && !heater_fault))
    else $error("heater drive disagrees with control bit");
  heater_reset_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    reset_write_s |=> boot_entered_s ##0 !o_heater_on)
    else $error("reset request did not restart boot");
  overcurrent_stop_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && overcurrent && ctrl.heater_on && !wr_ctrl
    |=> heater_fault && !o_heater_on)
    else $error("overcurrent did not stop heater");
  standby_sleep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && wr_ctrl && shift[2:0] == `OP_SLEEP
    && op_state == st_standby |=> op_state == st_sleep)
    else $error("sleep request left device in standby");
  boot_fail_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && op_state == st_boot && boot_started && i_boot_done
    && i_boot_fail && !wr_ctrl |=> op_state == st_sleep && boot_fault)
    else $error("boot failure not flagged");
  one_shot_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && op_state == st_measure && i_conversion_done && !wr_ctrl
    && ctrl.standby_interval == `STBY_ONE_SHOT |=> op_state == st_sleep)
    else $error("one-shot did not return to sleep");
  repeat_wait_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && op_state == st_measure && i_conversion_done && !wr_ctrl
    && ctrl.op_request == `OP_MEASURE && ctrl.standby_interval == `STBY_100
    |=> op_state == st_standby && timer == `TIMER_W'(STBY_100_CYCLES - 1))
    else $error("repeat standby time wrong");
  wake_nack_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && link == link_addr && scl_fall && !start_cond
    && !stop_cond && cnt == `BYTE_BITS && op_state == st_wake
    |=> link == link_idle && o_sda_oe_n)
    else $error("address acknowledged while waking");
  prohibited_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clock_en && wr_ctrl && shift[2:0] == `OP_PROHIBITED
    && op_state == st_sleep |=> op_state == st_sleep && setting_fault
    && !o_conversion_start)
    else $error("prohibited request started work");
endmodule : sensor_state_heater_control
`default_nettype wire

// [verif/i2c_host_model.sv]
// host-side two-wire serial master model for the sensor bench
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter int NACK_GAP_NS = 2000
) (
  input wire logic i_sda,
  output var logic o_scl,
  output var logic o_sda_low
);
  // ****************
  // bit level
  // ****************
  // idle bus: both lines released, clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // one 64 ns bit, clock low on entry and exit
  task automatic bit_io(input logic b, output logic r);
    #16 o_sda_low = !b;
    #16 o_scl = 1'b1;
    r = i_sda;
    #32 o_scl = 1'b0;
  endtask : bit_io

  // start or repeated start, data falls while clock high
  task automatic start;
    #16 o_sda_low = 1'b0;
    #16 o_scl = 1'b1;
    #16 o_sda_low = 1'b1;
    #16 o_scl = 1'b0;
  endtask : start

  // stop, then leave both lines released
  task automatic stop;
    #16 o_sda_low = 1'b1;
    #16 o_scl = 1'b1;
    #16 o_sda_low = 1'b0;
    #32;
  endtask : stop

  // msb first byte, returns the ninth bit level as nack
  task automatic byte_out(input logic [7:0] d, output logic nk);
    for (int i = 7; i >= 0; i--) bit_io(d[i], nk);
    bit_io(1'b1, nk);
  endtask : byte_out

  // ****************
  // transfers
  // ****************
  // pointer write then data write, or pointer then restart and one read
  task automatic xfer(input logic [6:0] a, input logic [7:0] p,
                      input logic rd, input logic [7:0] wd,
                      output logic [7:0] q, output logic nk);
    logic n2;
    q = 8'h00;
    start;
    byte_out({a, 1'b0}, nk);
    if (!nk) begin
      byte_out(p, n2);
      if (rd) begin
        start;
        byte_out({a, 1'b1}, n2);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
        bit_io(1'b1, n2);
      end else begin
        byte_out(wd, n2);
      end
    end
    stop;
    if (nk) #NACK_GAP_NS;
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// [verif/tb_sensor_state_heater_control.sv]
// self-checking bench of the sensor state and heater controller
`timescale 1ns/10ps
`default_nettype none
`include "sensor_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); \
  end end
module tb_sensor_state_heater_control;
  import sensor_pkg::*;
  localparam int N100 = 200;
  localparam int N400 = 400;
  localparam int N1000 = 800;
  localparam int HEAT_WAIT = 50;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_heater_overcurrent = 1'b0;
  logic i_conversion_done = 1'b0;
  logic i_boot_done = 1'b0;
  logic i_boot_fail = 1'b0;
  logic o_sda_out, o_sda_oe_n, o_heater_on, o_conversion_start;
  logic o_boot_start, o_data_ready;
  logic [2:0] o_state;
  logic scl, sda_low, boot_fail_req = 1'b0, nk;
  logic [7:0] rd;
  wire logic sda;
  int fail_count = 0, n_compared = 0, n_conv = 0, n_boot = 0, n_stby = 0;
  int cdly = 0, bdly = 0;
  integer seed = 32'hfd416422;

  // open-drain data line with pull-up
  assign sda = !(sda_low | !o_sda_oe_n);

  sensor_state_heater_control #(.STBY_100_CYCLES(N100),
    .STBY_400_CYCLES(N400), .STBY_1000_CYCLES(N1000)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_en(1'b1),
    .i_scl(scl), .i_sda(sda), .i_heater_overcurrent(i_heater_overcurrent),
    .i_conversion_done(i_conversion_done), .i_boot_done(i_boot_done),
    .i_boot_fail(i_boot_fail), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .o_heater_on(o_heater_on),
    .o_conversion_start(o_conversion_start), .o_boot_start(o_boot_start),
    .o_data_ready(o_data_ready), .o_state(o_state));

  i2c_host_model #(.NACK_GAP_NS(2000)) host (
    .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // clock
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  // converter and boot loader stand-ins; random conversion length
  always @(posedge i_clock) begin
    i_conversion_done <= (cdly == 1);
    i_boot_done <= (bdly == 1);
    i_boot_fail <= boot_fail_req;
    n_stby <= n_stby + int'(o_state === `CODE_STANDBY);
    if (o_conversion_start === 1'b1) begin
      n_conv <= n_conv + 1;
      cdly <= 20 + {$random(seed)} % 16;
    end else if (cdly > 0) cdly <= cdly - 1;
    if (o_boot_start === 1'b1) begin
      n_boot <= n_boot + 1;
      bdly <= 10;
    end else if (bdly > 0) bdly <= bdly - 1;
  end

  // ****************
  // helpers
  // ****************
  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int k = 0; k < lim && o_state !== s; k++) @(negedge i_clock);
    if (o_state !== s) begin
      fail_count++;
      end_sim;
    end
  endtask : wait_st

  task automatic wait_conv(input int lim);
    int c;
    c = n_conv;
    for (int k = 0; k < lim && n_conv == c; k++) @(negedge i_clock);
    if (n_conv == c) begin
      fail_count++;
      end_sim;
    end
  endtask : wait_conv

  // writes in standby wait for the next measure, clear of the wake window
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    if (o_state === `CODE_STANDBY) wait_conv(N1000 + 100);
    host.xfer(a, `CTRL_OFFSET, 1'b0, d, rd, nk);
  endtask : wreg

  task automatic rdreg(input logic [6:0] a, input logic [7:0] p);
    host.xfer(a, p, 1'b1, 8'h00, rd, nk);
  endtask : rdreg

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clock);
    fail_count++;
    end_sim;
  end

  // ****************
  // main sequence
  // ****************
  initial begin : main
    logic hb;
    int c;
    int t;
    logic [2:0] codes [3];
    int lens [3];
    codes = '{`STBY_100, `STBY_400, `STBY_1000};
    lens = '{N100, N400, N1000};
    repeat (8) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (40) @(negedge i_clock);
    `CHK(n_boot, 1)
    rdreg(`ADDR_NORMAL, `CTRL_OFFSET);
    `CHK(rd, `CTRL_RESET)
    `CHK(o_heater_on, 1'b0)
    hb = 1'($random(seed));
    wreg(`ADDR_NORMAL, {1'b0, `STBY_ONE_SHOT, hb, `OP_MEASURE});
    `CHK(o_heater_on, hb)
    wait_st(`CODE_SLEEP, 300);
    `CHK(n_conv, 1)
    `CHK(n_stby, 0)
    `CHK(o_data_ready, 1'b1)
    rdreg(`ADDR_NORMAL, `CTRL_OFFSET);
    `CHK(rd, {1'b0, `STBY_ONE_SHOT, hb, `OP_MEASURE})
    // each repeat interval, timed from standby entry to next start
    for (int i = 0; i < 3; i++) begin
      wreg(`ADDR_NORMAL, {1'b0, codes[i], 1'b0, `OP_MEASURE});
      wait_conv(N1000 + 200);
      wait_st(`CODE_STANDBY, 100);
      c = n_conv;
      for (t = 0; t < 2000 && n_conv == c; t++) @(negedge i_clock);
      `CHK(t >= lens[i] && t <= lens[i] + 30, 1'b1)
    end
    // address byte ends about 120 clocks after the call, mid wake window
    wait_st(`CODE_STANDBY, 200);
    repeat (N1000 - 110) @(negedge i_clock);
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(nk, 1'b1)
    wait_st(`CODE_STANDBY, 2000);
    c = n_conv;
    host.xfer(`ADDR_NORMAL, `CTRL_OFFSET, 1'b0,
              {1'b0, `STBY_1000, 1'b0, `OP_SLEEP}, rd, nk);
    repeat (N1000) @(negedge i_clock);
    `CHK(n_conv, c)
    `CHK(o_state, `CODE_SLEEP)
    wreg(`ADDR_NORMAL, {1'b0, `STBY_100, 1'b0, `OP_PROHIBITED});
    repeat (300) @(negedge i_clock);
    `CHK(n_conv, c)
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(rd[4], 1'b1)
    `CHK(rd[2:0], `CODE_SLEEP)
    wreg(`ADDR_NORMAL, {1'b0, `STBY_ONE_SHOT, 1'b1, `OP_SLEEP});
    `CHK(o_heater_on, 1'b1)
    repeat (HEAT_WAIT) @(posedge i_clock);
    i_heater_overcurrent <= 1'b1;
    repeat (12) @(negedge i_clock);
    `CHK(o_heater_on, 1'b0)
    @(posedge i_clock);
    i_heater_overcurrent <= 1'b0;
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(rd[6], 1'b1)
    wreg(`ADDR_NORMAL, {1'b0, `STBY_ONE_SHOT, 1'b0, `OP_SLEEP});
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(rd[6], 1'b0)
    boot_fail_req = 1'b1;
    wreg(`ADDR_NORMAL, {5'h00, `OP_RESET});
    repeat (60) @(negedge i_clock);
    `CHK(n_boot, 2)
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(nk, 1'b1)
    rdreg(`ADDR_BOOT_FAULT, `STATUS_OFFSET);
    `CHK(rd[5], 1'b1)
    `CHK(rd[2:0], `CODE_SLEEP)
    rdreg(`ADDR_BOOT_FAULT, `CTRL_OFFSET);
    `CHK(rd, `CTRL_RESET)
    boot_fail_req = 1'b0;
    wreg(`ADDR_BOOT_FAULT, {5'h00, `OP_RESET});
    repeat (60) @(negedge i_clock);
    rdreg(`ADDR_NORMAL, `STATUS_OFFSET);
    `CHK(nk, 1'b0)
    `CHK(rd[5], 1'b0)
    // open-drain data output never drives high
    `CHK(o_sda_out, 1'b0)
    end_sim;
  end
endmodule : tb_sensor_state_heater_control
`default_nettype wire
